// ### dv/ldp_link_monitor.sv
// Link protocol checker for the local DMA port
`timescale 1ns/1ps
module ldp_link_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hold_n,
    input wire logic req,
    input wire logic tsel_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic ack_n,
    input wire logic dev_oe_n
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    sequence s_strobe;
        !rd_n || !wr_n;
    endsequence
    sequence s_rd8;
        !rd_n [*8] ##1 rd_n;
    endsequence
    sequence s_wr8;
        !wr_n [*8] ##1 wr_n;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_ack_tsel_excl: assert property (ack_n || tsel_n)
        else $error("ack and select low together");
    chk_strobe_excl: assert property (rd_n || wr_n)
        else $error("read and write strobes together");
    chk_ack_with_strobe: assert property ($fell(ack_n) |-> s_strobe)
        else $error("ack without strobe");
    chk_ack_needs_req: assert property ($fell(ack_n) |-> req)
        else $error("ack without request");
    chk_tsel_first: assert property (
        $fell(tsel_n) |-> (rd_n && wr_n) ##1 s_strobe)
        else $error("select not ahead of strobe");
    // Three cycles of sync and register lag before the strobes must drop
    chk_hold_quiet: assert property (!hold_n [*4] |-> rd_n && wr_n)
        else $error("strobe under hold");
    chk_write_drive: assert property (!wr_n |-> !dev_oe_n)
        else $error("write strobe without port drive");
    // Hold restarts the count, so those attempts are dropped
    chk_read_length: assert property (
        disable iff (rst_i || !hold_n) $fell(rd_n) |-> s_rd8)
        else $error("read strobe length wrong");
    chk_write_length: assert property (
        disable iff (rst_i || !hold_n) $fell(wr_n) |-> s_wr8)
        else $error("write strobe length wrong");
endmodule

// ### dv/local_dma_port_test.sv
// Testbench joining port and peripheral over the local link
`timescale 1ns/1ps
module local_dma_port_test;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, pci_req;
    logic        pci_gnt, irq, inta, inta_oe_n, irq_req, hold, want;
    logic        rx_valid, rx_dma, tgt_sel, in_reset;
    logic [7:0]  wb_adr;
    logic [31:0] wb_wdat, wb_rdat, rd, dma_word, tgt_word, rx_word;
    int          err_count = 0;
    int          check_count = 0;
    ////////////////////////////////////////////////////////////////////////
    ldp_link_if u_ldp_link_if ();
    ldp_device u_ldp_device (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pci_req_o(pci_req),
        .pci_gnt_i(pci_gnt), .irq_o(irq), .inta_o(inta),
        .inta_oe_n_o(inta_oe_n), .lnk(u_ldp_link_if));
    ldp_peripheral u_ldp_peripheral (.clk_i(clk_i), .rst_i(rst_i),
        .irq_req_i(irq_req), .hold_i(hold), .dma_want_i(want),
        .dma_word_i(dma_word), .tgt_word_i(tgt_word),
        .rx_word_o(rx_word), .rx_valid_o(rx_valid), .rx_dma_o(rx_dma),
        .tgt_sel_o(tgt_sel), .in_reset_o(in_reset),
        .lnk(u_ldp_link_if));
    ldp_link_monitor u_ldp_link_monitor (.clk_i(clk_i), .rst_i(rst_i),
        .hold_n(u_ldp_link_if.hold_n), .req(u_ldp_link_if.req),
        .tsel_n(u_ldp_link_if.tsel_n), .rd_n(u_ldp_link_if.rd_n),
        .wr_n(u_ldp_link_if.wr_n), .ack_n(u_ldp_link_if.ack_n),
        .dev_oe_n(u_ldp_link_if.dev_oe_n));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task chk(input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Slave answer time is not assumed; the watchdog ends a hang
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task wait_irq;
        while (irq !== 1'b1) @(posedge clk_i);
        wb(1'b1, ldp_pkg::OFS_STAT, 32'h7);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        wb(1'b0, ldp_pkg::OFS_MASK, 32'h0);
        chk(32'h7, rd);
        wb(1'b0, ldp_pkg::OFS_ID_CAT, 32'h0);
        chk({ldp_pkg::CATEGORY_DEF, ldp_pkg::VERSION_DEF}, rd);
        wb(1'b1, ldp_pkg::OFS_ID_PART, 32'hFFFFFFFF);
        wb(1'b0, ldp_pkg::OFS_ID_PART, 32'h0);
        chk({ldp_pkg::PART_DEF, ldp_pkg::MAKER_DEF}, rd);
        wb(1'b0, ldp_pkg::OFS_ID_BOARD, 32'h0);
        chk({ldp_pkg::BOARD_DEF, ldp_pkg::BOARD_MAKER_DEF}, rd);
        wb(1'b0, 8'h3C, 32'h0);
        chk(32'h0, rd);
        wb(1'b0, ldp_pkg::OFS_STATE, 32'h0);
        chk(32'h0, rd);
        $display("registers done");
    endtask
    task t_irq;
        irq_req <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk(32'h4, 32'({irq, inta, inta_oe_n}));
        wb(1'b1, ldp_pkg::OFS_MASK, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(32'h1, 32'({irq, inta_oe_n}));
        irq_req <= 1'b0;
        repeat (6) @(posedge clk_i);
        wb(1'b1, ldp_pkg::OFS_STAT, 32'h1);
        wb(1'b0, ldp_pkg::OFS_STAT, 32'h0);
        chk(32'h0, rd);
        wb(1'b1, ldp_pkg::OFS_MASK, 32'h7);
        $display("interrupt done");
    endtask
    task t_dma(input logic dir, input logic pause);
        wb(1'b1, ldp_pkg::OFS_DMA_DATA, 32'h3C96E127);
        wb(1'b1, ldp_pkg::OFS_CTRL, {29'h0, dir, 2'b10});
        want <= 1'b1;
        while (pci_req !== 1'b1) @(posedge clk_i);
        pci_gnt <= 1'b1;
        while (u_ldp_link_if.ack_n !== 1'b0) @(posedge clk_i);
        chk(32'(dir), 32'(u_ldp_link_if.rd_n));
        want <= 1'b0;
        hold <= pause;
        repeat (8) @(posedge clk_i);
        if (pause) chk(32'h3, 32'({u_ldp_link_if.rd_n, u_ldp_link_if.wr_n}));
        hold <= 1'b0;
        if (dir) begin
            while (rx_valid !== 1'b1) @(posedge clk_i);
            chk(32'h3C96E127, rx_word);
            chk(32'h1, 32'(rx_dma));
        end
        wait_irq();
        pci_gnt <= 1'b0;
        wb(1'b0, ldp_pkg::OFS_DMA_DATA, 32'h0);
        if (!dir) chk(dma_word, rd);
        wb(1'b1, ldp_pkg::OFS_CTRL, 32'h0);
        $display("dma done");
    endtask
    task t_tgt;
        wb(1'b1, ldp_pkg::OFS_TGT_DATA, 32'h7E01C4D2);
        wb(1'b1, ldp_pkg::OFS_TGT_CMD, 32'h3);
        while (tgt_sel !== 1'b1) @(posedge clk_i);
        chk(32'h1, 32'(u_ldp_link_if.ack_n));
        while (rx_valid !== 1'b1) @(posedge clk_i);
        chk(32'h7E01C4D2, rx_word);
        chk(32'h0, 32'(rx_dma));
        wait_irq();
        wb(1'b1, ldp_pkg::OFS_TGT_CMD, 32'h1);
        wait_irq();
        wb(1'b0, ldp_pkg::OFS_TGT_DATA, 32'h0);
        chk(tgt_word, rd);
        $display("target done");
    endtask
    task t_peripheral_reset_ctl_bit;
        wb(1'b1, ldp_pkg::OFS_CTRL, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(32'h0, 32'(u_ldp_link_if.lreset_n));
        while (in_reset !== 1'b1) @(posedge clk_i);
        wb(1'b1, ldp_pkg::OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(32'h1, 32'(u_ldp_link_if.lreset_n));
        $display("local reset done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        stop_test();
    end
    initial begin
        rst_i = 1'b1;
        {wb_cyc, wb_stb, wb_we, pci_gnt, irq_req, hold, want} = 7'h0;
        wb_adr = 8'h0;
        wb_wdat = 32'h0;
        dma_word = 32'hA5C30F18;
        tgt_word = 32'h19B462AF;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_irq();
        t_dma(1'b0, 1'b0);
        t_dma(1'b1, 1'b1);
        t_tgt();
        t_peripheral_reset_ctl_bit();
        stop_test();
    end
endmodule

// ### logic/ldp_device.sv
// Port end: software register slave, DMA and target sequencer, local link
//
// Operation
// - Peripheral interrupt request raises host interrupt.
// - Host interrupt is open-drain, driven only low.
// - Hold suspends transfers until released.
// - DMA request makes port request bus permission.
// - Peripheral drives data for local reads.
// - Port drives data for local writes.
// - Target select asserted before target transfer.
// - Acknowledge and target select never together.
// - Read strobe reads peripheral target memory.
// - DMA local read pairs acknowledge with read.
// - Write strobe writes peripheral target memory.
// - DMA local write pairs acknowledge with write.
// - Acknowledge low grants peripheral a DMA transfer.
// - Local reset output follows control bit 0.
// - Category register read-only, parameter, default FF0000.
// - Identifier widths sixteen bits, version eight bits.
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module ldp_device #(
    parameter logic [23:0] FUNCTION_CATEGORY      = ldp_pkg::CATEGORY_DEF,
    parameter logic [15:0] PART_IDENTIFIER        = ldp_pkg::PART_DEF,
    parameter logic [15:0] MAKER_IDENTIFIER       = ldp_pkg::MAKER_DEF,
    parameter logic [7:0]  VERSION_IDENTIFIER     = ldp_pkg::VERSION_DEF,
    parameter logic [15:0] BOARD_IDENTIFIER       = ldp_pkg::BOARD_DEF,
    parameter logic [15:0] BOARD_MAKER_IDENTIFIER = ldp_pkg::BOARD_MAKER_DEF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             pci_req_o,
    input  wire logic        pci_gnt_i,
    output logic             irq_o,
    output logic             inta_o,
    output logic             inta_oe_n_o,
    ldp_link_if.dev          lnk
);
    typedef struct packed {
        ldp_pkg::ldp_state_t st;
        logic [3:0]          cnt;
        logic                is_tgt;
        logic                wr_dir;
        logic [2:0]          ctrl;
        logic [2:0]          stat;
        logic [2:0]          mask;
        logic                tgt_pend;
        logic                tgt_wr;
        logic [31:0]         dma_tx;
        logic [31:0]         dma_rx;
        logic [31:0]         tgt_tx;
        logic [31:0]         tgt_rx;
        logic                ack;
        logic [31:0]         rdat;
        logic                pci_req;
        logic                ack_n;
        logic                tsel_n;
        logic                rd_n;
        logic                wr_n;
        logic                oe_n;
        logic [31:0]         ldat;
        logic                irq;
        logic                od_oe_n;
        logic                lreset_n;
    } ldp_dev_state_t;

    ldp_dev_state_t s_ff;
    ldp_dev_state_t nxt_s;
    logic [34:0]    sync_q;
    logic           irq_req_n;
    logic           hold_n;
    logic           dma_req;
    logic [31:0]    ldat_s;
    logic [31:0]    wmerge;
    logic           ev_dma;
    logic           ev_tgt;

    ldp_sync #(
        .W       (35),
        .RST_VAL (35'h600000000)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({lnk.irq_n, lnk.hold_n, lnk.req, lnk.ldat}),
        .q_o   (sync_q)
    );

    assign irq_req_n = sync_q[34];
    assign hold_n    = sync_q[33];
    assign dma_req   = sync_q[32];
    assign ldat_s    = sync_q[31:0];

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_s  = s_ff;
        ev_dma = 1'b0;
        ev_tgt = 1'b0;
        nxt_s.ack = 1'b0;
        wmerge = 32'h0;

        unique case (s_ff.st)
            ldp_pkg::LDP_IDLE: begin
                // Target traffic goes first: a host access must not wait on
                // a peripheral that keeps its DMA request up
                if (s_ff.tgt_pend && hold_n) begin
                    nxt_s.st       = ldp_pkg::LDP_TSEL;
                    nxt_s.tgt_pend = 1'b0;
                    nxt_s.is_tgt   = 1'b1;
                    nxt_s.wr_dir   = s_ff.tgt_wr;
                    nxt_s.ldat     = s_ff.tgt_tx;
                end else if (s_ff.ctrl[ldp_pkg::CTRL_DMA_EN_BIT] &&
                             dma_req && hold_n) begin
                    nxt_s.st     = ldp_pkg::LDP_DREQ;
                    nxt_s.is_tgt = 1'b0;
                    nxt_s.wr_dir = s_ff.ctrl[ldp_pkg::CTRL_DMA_DIR_BIT];
                    nxt_s.ldat   = s_ff.dma_tx;
                end
            end
            ldp_pkg::LDP_DREQ: begin
                if (!s_ff.ctrl[ldp_pkg::CTRL_DMA_EN_BIT]) begin
                    nxt_s.st = ldp_pkg::LDP_GAP;
                end else if (pci_gnt_i && hold_n) begin
                    nxt_s.st  = ldp_pkg::LDP_XFER;
                    nxt_s.cnt = 4'(ldp_pkg::STROBE_CYC - 1);
                end
            end
            ldp_pkg::LDP_TSEL: begin
                nxt_s.st  = ldp_pkg::LDP_XFER;
                nxt_s.cnt = 4'(ldp_pkg::STROBE_CYC - 1);
            end
            ldp_pkg::LDP_XFER: begin
                if (!hold_n) begin
                    // Restart the full strobe so stale data is never taken;
                    // one count extra, as the release cycle uses one up
                    nxt_s.cnt = 4'(ldp_pkg::STROBE_CYC);
                end else if (s_ff.cnt == 4'h0) begin
                    nxt_s.st = ldp_pkg::LDP_GAP;
                    if (s_ff.is_tgt) begin
                        ev_tgt = 1'b1;
                        if (!s_ff.wr_dir) begin
                            nxt_s.tgt_rx = ldat_s;
                        end
                    end else begin
                        ev_dma = 1'b1;
                        if (!s_ff.wr_dir) begin
                            nxt_s.dma_rx = ldat_s;
                        end
                    end
                end else begin
                    nxt_s.cnt = s_ff.cnt - 4'h1;
                end
            end
            ldp_pkg::LDP_GAP: begin
                nxt_s.st = ldp_pkg::LDP_IDLE;
            end
            default: begin
                nxt_s.st = ldp_pkg::LDP_IDLE;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        if (wb_cyc_i && wb_stb_i && !s_ff.ack) begin
            nxt_s.ack = 1'b1;
            unique case (wb_adr_i)
                ldp_pkg::OFS_CTRL:     nxt_s.rdat = {29'h0, s_ff.ctrl};
                ldp_pkg::OFS_STAT:     nxt_s.rdat = {29'h0, s_ff.stat};
                ldp_pkg::OFS_MASK:     nxt_s.rdat = {29'h0, s_ff.mask};
                ldp_pkg::OFS_DMA_DATA: nxt_s.rdat = s_ff.dma_rx;
                ldp_pkg::OFS_TGT_CMD:  nxt_s.rdat = {30'h0, s_ff.tgt_wr,
                                                     s_ff.tgt_pend};
                ldp_pkg::OFS_TGT_DATA: nxt_s.rdat = s_ff.tgt_rx;
                ldp_pkg::OFS_ID_PART:  nxt_s.rdat = {PART_IDENTIFIER,
                                                     MAKER_IDENTIFIER};
                ldp_pkg::OFS_ID_CAT:   nxt_s.rdat = {FUNCTION_CATEGORY,
                                                     VERSION_IDENTIFIER};
                ldp_pkg::OFS_ID_BOARD: nxt_s.rdat = {BOARD_IDENTIFIER,
                                                BOARD_MAKER_IDENTIFIER};
                ldp_pkg::OFS_STATE:    nxt_s.rdat = {26'h0, !hold_n,
                                                     s_ff.is_tgt,
                                                     s_ff.tgt_pend, s_ff.st};
                default:               nxt_s.rdat = 32'h0;
            endcase
            if (wb_we_i) begin
                unique case (wb_adr_i)
                    ldp_pkg::OFS_CTRL: begin
                        wmerge = lane_merge({29'h0, s_ff.ctrl}, wb_dat_i,
                                            wb_sel_i);
                        nxt_s.ctrl = wmerge[2:0];
                    end
                    ldp_pkg::OFS_STAT: begin
                        if (wb_sel_i[0]) begin
                            nxt_s.stat = s_ff.stat & ~wb_dat_i[2:0];
                        end
                    end
                    ldp_pkg::OFS_MASK: begin
                        wmerge = lane_merge({29'h0, s_ff.mask}, wb_dat_i,
                                            wb_sel_i);
                        nxt_s.mask = wmerge[2:0];
                    end
                    ldp_pkg::OFS_DMA_DATA: begin
                        nxt_s.dma_tx = lane_merge(s_ff.dma_tx, wb_dat_i,
                                                  wb_sel_i);
                    end
                    ldp_pkg::OFS_TGT_CMD: begin
                        if (wb_sel_i[0] && wb_dat_i[ldp_pkg::TGT_GO_BIT]) begin
                            nxt_s.tgt_pend = 1'b1;
                            nxt_s.tgt_wr   = wb_dat_i[ldp_pkg::TGT_WR_BIT];
                        end
                    end
                    ldp_pkg::OFS_TGT_DATA: begin
                        nxt_s.tgt_tx = lane_merge(s_ff.tgt_tx, wb_dat_i,
                                                  wb_sel_i);
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Events set after the clear so a same-cycle event is kept
        nxt_s.stat[ldp_pkg::IRQ_LOCAL_BIT] = nxt_s.stat[ldp_pkg::IRQ_LOCAL_BIT]
                                             | !irq_req_n;
        nxt_s.stat[ldp_pkg::IRQ_DMA_BIT] = nxt_s.stat[ldp_pkg::IRQ_DMA_BIT]
                                           | ev_dma;
        nxt_s.stat[ldp_pkg::IRQ_TGT_BIT] = nxt_s.stat[ldp_pkg::IRQ_TGT_BIT]
                                           | ev_tgt;

        ////////////////////////////////////////////////////////////////////
        nxt_s.pci_req = (nxt_s.st == ldp_pkg::LDP_DREQ) ||
                        (nxt_s.st == ldp_pkg::LDP_XFER && !nxt_s.is_tgt);
        nxt_s.ack_n   = !(nxt_s.st == ldp_pkg::LDP_XFER &&
                          !nxt_s.is_tgt);
        nxt_s.tsel_n  = !(nxt_s.is_tgt &&
                          (nxt_s.st == ldp_pkg::LDP_TSEL ||
                           nxt_s.st == ldp_pkg::LDP_XFER));
        nxt_s.rd_n    = !(nxt_s.st == ldp_pkg::LDP_XFER && hold_n &&
                          !nxt_s.wr_dir);
        nxt_s.wr_n    = !(nxt_s.st == ldp_pkg::LDP_XFER && hold_n &&
                          nxt_s.wr_dir);
        nxt_s.oe_n    = !(nxt_s.st == ldp_pkg::LDP_XFER && nxt_s.wr_dir);
        nxt_s.irq     = |(nxt_s.stat & nxt_s.mask);
        nxt_s.od_oe_n = !nxt_s.irq;
        nxt_s.lreset_n = !nxt_s.ctrl[ldp_pkg::CTRL_PERIPHERAL_RESET_CTL_BIT_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff          <= '0;
            s_ff.st       <= ldp_pkg::LDP_IDLE;
            s_ff.ctrl     <= ldp_pkg::CTRL_RST;
            s_ff.mask     <= ldp_pkg::MASK_RST;
            s_ff.ack_n    <= 1'b1;
            s_ff.tsel_n   <= 1'b1;
            s_ff.rd_n     <= 1'b1;
            s_ff.wr_n     <= 1'b1;
            s_ff.oe_n     <= 1'b1;
            s_ff.od_oe_n  <= 1'b1;
            s_ff.lreset_n <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign wb_dat_o     = s_ff.rdat;
    assign wb_ack_o     = s_ff.ack;
    assign pci_req_o    = s_ff.pci_req;
    assign irq_o        = s_ff.irq;
    // Open-drain line: the level is always low, only the enable moves
    assign inta_o       = 1'b0;
    assign inta_oe_n_o  = s_ff.od_oe_n;
    assign lnk.ack_n    = s_ff.ack_n;
    assign lnk.tsel_n   = s_ff.tsel_n;
    assign lnk.rd_n     = s_ff.rd_n;
    assign lnk.wr_n     = s_ff.wr_n;
    assign lnk.dev_oe_n = s_ff.oe_n;
    assign lnk.dev_dat  = s_ff.ldat;
    assign lnk.lreset_n = s_ff.lreset_n;
endmodule

// ### logic/ldp_link_if.sv
// Local-side link between the port and the peripheral
`timescale 1ns/1ps
interface ldp_link_if;
    logic        irq_n;
    logic        hold_n;
    logic        req;
    logic        tsel_n;
    logic        rd_n;
    logic        wr_n;
    logic        ack_n;
    logic        lreset_n;
    logic [31:0] dev_dat;
    logic        dev_oe_n;
    logic [31:0] per_dat;
    logic        per_oe_n;
    logic [31:0] ldat;

    // Shared data wire; reads zero when nobody drives
    assign ldat = !dev_oe_n ? dev_dat : (!per_oe_n ? per_dat : 32'h0);

    modport dev (
        input  irq_n, hold_n, req, ldat,
        output tsel_n, rd_n, wr_n, ack_n, lreset_n, dev_dat, dev_oe_n
    );
    modport per (
        input  tsel_n, rd_n, wr_n, ack_n, lreset_n, ldat,
        output irq_n, hold_n, req, per_dat, per_oe_n
    );
endinterface

// ### logic/ldp_peripheral.sv
// Peripheral end: answers strobes, raises requests, holds and interrupts
`timescale 1ns/1ps
module ldp_peripheral (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        irq_req_i,
    input  wire logic        hold_i,
    input  wire logic        dma_want_i,
    input  wire logic [31:0] dma_word_i,
    input  wire logic [31:0] tgt_word_i,
    output logic      [31:0] rx_word_o,
    output logic             rx_valid_o,
    output logic             rx_dma_o,
    output logic             tgt_sel_o,
    output logic             in_reset_o,
    ldp_link_if.per          lnk
);
    typedef struct packed {
        logic        irq_n;
        logic        hold_n;
        logic        req;
        logic [31:0] ldat;
        logic        oe_n;
        logic [31:0] rx_word;
        logic        rx_valid;
        logic        rx_dma;
        logic        tsel;
        logic        wr_prev_n;
        logic        in_reset;
    } ldp_per_state_t;

    ldp_per_state_t s_ff;
    ldp_per_state_t nxt_s;
    logic [36:0]    sync_q;
    logic           tsel_n_s;
    logic           rd_n_s;
    logic           wr_n_s;
    logic           ack_n_s;
    logic           lreset_n_s;
    logic [31:0]    ldat_s;

    ldp_sync #(
        .W       (37),
        .RST_VAL (37'h1F00000000)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({lnk.tsel_n, lnk.rd_n, lnk.wr_n, lnk.ack_n, lnk.lreset_n,
                 lnk.ldat}),
        .q_o   (sync_q)
    );

    assign tsel_n_s   = sync_q[36];
    assign rd_n_s     = sync_q[35];
    assign wr_n_s     = sync_q[34];
    assign ack_n_s    = sync_q[33];
    assign lreset_n_s = sync_q[32];
    assign ldat_s     = sync_q[31:0];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_s           = s_ff;
        nxt_s.rx_valid  = 1'b0;
        nxt_s.wr_prev_n = wr_n_s;
        if (!lreset_n_s) begin
            // Held in reset by the port: quiet on every line
            nxt_s.irq_n    = 1'b1;
            nxt_s.hold_n   = 1'b1;
            nxt_s.req      = 1'b0;
            nxt_s.oe_n     = 1'b1;
            nxt_s.tsel     = 1'b0;
            nxt_s.in_reset = 1'b1;
        end else begin
            nxt_s.in_reset = 1'b0;
            nxt_s.irq_n    = !irq_req_i;
            nxt_s.hold_n   = !hold_i;
            // Request drops while granted so one grant moves one word
            nxt_s.req      = dma_want_i && ack_n_s;
            nxt_s.tsel     = !tsel_n_s;
            nxt_s.oe_n     = rd_n_s;
            nxt_s.ldat     = ack_n_s ? tgt_word_i : dma_word_i;
            if (!wr_n_s) begin
                nxt_s.rx_word = ldat_s;
                nxt_s.rx_dma  = !ack_n_s;
            end
            if (wr_n_s && !s_ff.wr_prev_n) begin
                nxt_s.rx_valid = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff           <= '0;
            s_ff.irq_n     <= 1'b1;
            s_ff.hold_n    <= 1'b1;
            s_ff.oe_n      <= 1'b1;
            s_ff.wr_prev_n <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rx_word_o    = s_ff.rx_word;
    assign rx_valid_o   = s_ff.rx_valid;
    assign rx_dma_o     = s_ff.rx_dma;
    assign tgt_sel_o    = s_ff.tsel;
    assign in_reset_o   = s_ff.in_reset;
    assign lnk.irq_n    = s_ff.irq_n;
    assign lnk.hold_n   = s_ff.hold_n;
    assign lnk.req      = s_ff.req;
    assign lnk.per_dat  = s_ff.ldat;
    assign lnk.per_oe_n = s_ff.oe_n;
endmodule

// ### logic/ldp_pkg.sv
// Shared constants, register map and state codes of the local DMA port
package ldp_pkg;
    localparam int DW = 32;
    localparam int AW = 8;

    // Register byte offsets on the software bus
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STAT     = 8'h04;
    localparam logic [7:0] OFS_MASK     = 8'h08;
    localparam logic [7:0] OFS_DMA_DATA = 8'h0C;
    localparam logic [7:0] OFS_TGT_CMD  = 8'h10;
    localparam logic [7:0] OFS_TGT_DATA = 8'h14;
    localparam logic [7:0] OFS_ID_PART  = 8'h18;
    localparam logic [7:0] OFS_ID_CAT   = 8'h1C;
    localparam logic [7:0] OFS_ID_BOARD = 8'h20;
    localparam logic [7:0] OFS_STATE    = 8'h24;

    // Field positions
    localparam int CTRL_PERIPHERAL_RESET_CTL_BIT_BIT   = 0;
    localparam int CTRL_DMA_EN_BIT = 1;
    localparam int CTRL_DMA_DIR_BIT = 2;
    localparam int TGT_GO_BIT      = 0;
    localparam int TGT_WR_BIT      = 1;
    localparam int IRQ_LOCAL_BIT   = 0;
    localparam int IRQ_DMA_BIT     = 1;
    localparam int IRQ_TGT_BIT     = 2;
    localparam int IRQ_W           = 3;

    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h7;

    // Identification defaults; all but the category are arbitrary
    localparam logic [23:0] CATEGORY_DEF    = 24'hFF0000;
    localparam logic [15:0] PART_DEF        = 16'h5A17;
    localparam logic [15:0] MAKER_DEF       = 16'h1D2C;
    localparam logic [7:0]  VERSION_DEF     = 8'h03;
    localparam logic [15:0] BOARD_DEF       = 16'h0A0A;
    localparam logic [15:0] BOARD_MAKER_DEF = 16'h0C0C;

    // Strobe length on the local side
    localparam int CLK_NS     = 8;
    localparam int STROBE_NS  = 64;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = 4;

    typedef enum logic [2:0] {
        LDP_IDLE = 3'b000,
        LDP_DREQ = 3'b001,
        LDP_TSEL = 3'b010,
        LDP_XFER = 3'b011,
        LDP_GAP  = 3'b100
    } ldp_state_t;
endpackage

// ### logic/ldp_sync.sv
// Two-stage synchroniser, one stage pair per bit
`timescale 1ns/1ps
module ldp_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_ff <= RST_VAL[b];
                    sync_ff <= RST_VAL[b];
                end else begin
                    meta_ff <= d_i[b];
                    sync_ff <= meta_ff;
                end
            end
            assign q_o[b] = sync_ff;
        end
    endgenerate
endmodule
